// [include/wakeup_params.svh]
// Constants for the wake-up sensitivity and interrupt qualification block
`ifndef WAKEUP_PARAMS_SVH
`define WAKEUP_PARAMS_SVH
// Sensitivity codes shared by the wake detector and the main controller
`define WK_SENS_LOW 2'h0
`define WK_SENS_HIGH 2'h1
`define WK_SENS_FALL 2'h2
`define WK_SENS_RISE 2'h3
// Wake-up clear codes: pins take their own number, RTC a fixed code
`define WK_CLR_RTC 3'h7
`define WK_CLR_RSV_A 3'h5
`define WK_CLR_RSV_B 3'h6
// Priority level that keeps a source from being granted
`define WK_PRIO_OFF 3'h0
// Number of external wake pins served by the clear encoding
`define WK_EXT_PINS 5
`endif

// [include/wakeup_pkg.sv]
// Types for the wake-up sensitivity and interrupt qualification block
`include "wakeup_params.svh"
package wakeup_pkg;
    typedef enum logic [1:0] {
        SENS_LOW = `WK_SENS_LOW,
        SENS_HIGH = `WK_SENS_HIGH,
        SENS_FALL = `WK_SENS_FALL,
        SENS_RISE = `WK_SENS_RISE
    } sens_type;
    typedef logic [2:0] prio_type;
endpackage

// [include/wake_link_if.sv]
// Link between the main qualifier and the wake-side detector
`timescale 1ns/1ns
interface wake_link_if #(parameter int NSRC = 6);
    logic [NSRC-1:0] srcLevel;
    logic [NSRC-1:0][1:0] sensSel;
    logic [NSRC-1:0] wakeEn;
    logic [NSRC-1:0] clearHit;
    logic [NSRC-1:0] condReq;
    modport ctrl (output srcLevel, output sensSel, output wakeEn, output clearHit,
        input condReq);
    modport det (input srcLevel, input sensSel, input wakeEn, input clearHit,
        output condReq);
endinterface

// [rtl/wake_detector.sv]
// Wake-side detector: per-source edge or level sensitivity with enable
`timescale 1ns/1ns
`include "wakeup_params.svh"
module wake_detector
    import wakeup_pkg::*;
#(
    parameter int NSRC = 6
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Link to the main qualifier
    wake_link_if.det lnk
);
    // Elaboration check: the link needs at least one source
    generate
        if (NSRC < 1) begin : gBadSrc
            $error("NSRC must be at least 1");
        end
    endgenerate

    genvar g;
    generate
        for (g = 0; g < NSRC; g++) begin : gSrc
            logic prev_r, prev_nxt;
            logic pend_r, pend_nxt;
            logic riseSeen, fallSeen;
            sens_type mode;
            assign mode = sens_type'(lnk.sensSel[g]);
            assign riseSeen = lnk.srcLevel[g] & ~prev_r;
            assign fallSeen = ~lnk.srcLevel[g] & prev_r;
            // Next state; a new edge beats a clear in the same cycle
            always_comb begin
                prev_nxt = lnk.srcLevel[g];
                pend_nxt = 1'b0;
                lnk.condReq[g] = 1'b0;
                case (mode)
                    SENS_LOW: begin
                        lnk.condReq[g] = lnk.wakeEn[g] & ~lnk.srcLevel[g];
                    end
                    SENS_HIGH: begin
                        lnk.condReq[g] = lnk.wakeEn[g] & lnk.srcLevel[g];
                    end
                    SENS_FALL: begin
                        pend_nxt = (lnk.wakeEn[g] & fallSeen) | (pend_r & ~lnk.clearHit[g]);
                        lnk.condReq[g] = lnk.wakeEn[g] & pend_r;
                    end
                    SENS_RISE: begin
                        pend_nxt = (lnk.wakeEn[g] & riseSeen) | (pend_r & ~lnk.clearHit[g]);
                        lnk.condReq[g] = lnk.wakeEn[g] & pend_r;
                    end
                    default: begin
                        pend_nxt = 1'b0;
                    end
                endcase
            end
            // Register only
            always_ff @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    prev_r <= 1'b0;
                    pend_r <= 1'b0;
                end else begin
                    prev_r <= prev_nxt;
                    pend_r <= pend_nxt;
                end
            end
            chk_fall_latch: assert property (@(posedge sys_clk) disable iff (!rst_n)
                (mode == SENS_FALL && lnk.wakeEn[g] && fallSeen)
                |=> (mode != SENS_FALL || !lnk.wakeEn[g] || lnk.condReq[g]))
                else $error("falling edge not latched");
            chk_clear_drop: assert property (@(posedge sys_clk) disable iff (!rst_n)
                (lnk.clearHit[g] && !(riseSeen || fallSeen)) |=> !pend_r)
                else $error("wake clear did not drop request");
            chk_level_pass: assert property (@(posedge sys_clk) disable iff (!rst_n)
                (mode == SENS_HIGH) |-> (lnk.condReq[g] == (lnk.wakeEn[g] && lnk.srcLevel[g])))
                else $error("high level not passed");
        end
    endgenerate
endmodule // wake_detector

// [rtl/wakeup_interrupt_sensitivity.sv]
// Wake-up source qualification ahead of a small main interrupt controller
`timescale 1ns/1ns
`include "wakeup_params.svh"
module wakeup_interrupt_sensitivity
    import wakeup_pkg::*;
#(
    parameter int NUM_EXT = `WK_EXT_PINS
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Interrupt sources
    input wire logic [NUM_EXT-1:0] extIrqPin,
    input wire logic rtcIrq,
    // Wake detector configuration
    input wire logic [NUM_EXT:0][1:0] wakeSensitivitySel,
    input wire logic [NUM_EXT:0] wakeEnable,
    input wire logic [NUM_EXT-1:0] wakeUse,
    input wire logic wakeClearStrobe,
    input wire logic [2:0] wakeRequestClear,
    // Main controller configuration
    input wire logic [NUM_EXT:0][1:0] intcSensitivitySel,
    input wire logic [NUM_EXT:0][2:0] intcPriorityLevel,
    input wire logic intcClearStrobe,
    input wire logic [2:0] intcRequestClear,
    // Status and request outputs
    output logic [NUM_EXT:0] intcPending,
    output logic wakeUp,
    output logic irqReq,
    output logic [2:0] irqSource,
    output logic [2:0] irqLevel
);
    localparam int NSRC = NUM_EXT + 1;
    localparam int RTC = NUM_EXT;

    // Pin count must fit the three-bit clear code below the reserved codes
    generate
        if (NUM_EXT < 1 || NUM_EXT > `WK_EXT_PINS) begin : gBadPins
            $error("NUM_EXT out of range");
        end
    endgenerate

    // Wake clear code to one-hot source; reserved codes hit nothing
    function automatic logic [NSRC-1:0] wakeClearDecode(input logic [2:0] code);
        logic [NSRC-1:0] hit;
        hit = '0;
        if (code == `WK_CLR_RTC) begin
            hit[RTC] = 1'b1;
        end else if (32'(code) < NUM_EXT) begin
            hit[code] = 1'b1;
        end
        return hit;
    endfunction

    // Controller clear uses the plain source index
    function automatic logic [NSRC-1:0] intcClearDecode(input logic [2:0] code);
        logic [NSRC-1:0] hit;
        hit = '0;
        if (32'(code) < NSRC) begin
            hit[code] = 1'b1;
        end
        return hit;
    endfunction

    // Edge modes keep a sticky flag; level modes follow the line
    function automatic logic isEdgeSel(input logic [1:0] sel);
        return sel == `WK_SENS_FALL || sel == `WK_SENS_RISE;
    endfunction

    wake_link_if #(.NSRC(NSRC)) lnk ();
    logic [NSRC-1:0] srcLevel;
    logic [NSRC-1:0] routeWake;
    logic [NSRC-1:0] intcIn;
    logic [NSRC-1:0] intcHit;

    // Source bundle; RTC always counts as routed through the detector
    assign srcLevel = {rtcIrq, extIrqPin};
    assign routeWake = {1'b1, wakeUse};
    assign lnk.srcLevel = srcLevel;
    assign lnk.sensSel = wakeSensitivitySel;
    assign lnk.wakeEn = wakeEnable;
    assign lnk.clearHit = wakeClearStrobe ? wakeClearDecode(wakeRequestClear) : '0;
    assign intcHit = intcClearStrobe ? intcClearDecode(intcRequestClear) : '0;

    wake_detector #(.NSRC(NSRC)) uDet (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .lnk(lnk.det)
    );

    // Wake sources feed the conditioned level; others the raw pin
    assign intcIn = (routeWake & lnk.condReq) | (~routeWake & srcLevel);

    // Main controller detection state
    logic [NSRC-1:0] inPrev_r, inPrev_nxt;
    logic [NSRC-1:0] pend_r, pend_nxt;
    logic wakeUp_r, wakeUp_nxt;
    always_comb begin
        inPrev_nxt = intcIn;
        pend_nxt = pend_r;
        wakeUp_nxt = |lnk.condReq;
        for (int i = 0; i < NSRC; i++) begin
            case (sens_type'(intcSensitivitySel[i]))
                SENS_LOW: pend_nxt[i] = ~intcIn[i];
                SENS_HIGH: pend_nxt[i] = intcIn[i];
                SENS_FALL: pend_nxt[i] = (~intcIn[i] & inPrev_r[i]) | (pend_r[i] & ~intcHit[i]);
                SENS_RISE: pend_nxt[i] = (intcIn[i] & ~inPrev_r[i]) | (pend_r[i] & ~intcHit[i]);
                default: pend_nxt[i] = 1'b0;
            endcase
        end
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            inPrev_r <= '0;
            pend_r <= '0;
            wakeUp_r <= 1'b0;
        end else begin
            inPrev_r <= inPrev_nxt;
            pend_r <= pend_nxt;
            wakeUp_r <= wakeUp_nxt;
        end
    end

    // Priority pick: highest level wins, lowest index on a tie
    logic irqReq_r, irqReq_nxt;
    logic [2:0] irqSource_r, irqSource_nxt;
    prio_type irqLevel_r, irqLevel_nxt;
    always_comb begin
        irqReq_nxt = 1'b0;
        irqSource_nxt = 3'h0;
        irqLevel_nxt = `WK_PRIO_OFF;
        for (int i = 0; i < NSRC; i++) begin
            if (pend_r[i] && intcPriorityLevel[i] > irqLevel_nxt) begin
                irqReq_nxt = 1'b1;
                irqSource_nxt = 3'(i);
                irqLevel_nxt = intcPriorityLevel[i];
            end
        end
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            irqReq_r <= 1'b0;
            irqSource_r <= 3'h0;
            irqLevel_r <= `WK_PRIO_OFF;
        end else begin
            irqReq_r <= irqReq_nxt;
            irqSource_r <= irqSource_nxt;
            irqLevel_r <= irqLevel_nxt;
        end
    end

    // Outputs straight from flops
    assign intcPending = pend_r;
    assign wakeUp = wakeUp_r;
    assign irqReq = irqReq_r;
    assign irqSource = irqSource_r;
    assign irqLevel = irqLevel_r;

    chk_rtc_route: assert property (@(posedge sys_clk) disable iff (!rst_n)
        intcIn[RTC] == lnk.condReq[RTC])
        else $error("RTC bypassed the detector");
    chk_bypass_raw: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !wakeUse[0] |-> intcIn[0] == extIrqPin[0])
        else $error("non-wake pin not raw");
    chk_wake_route: assert property (@(posedge sys_clk) disable iff (!rst_n)
        wakeUse[0] |-> intcIn[0] == lnk.condReq[0])
        else $error("wake pin not conditioned");
    chk_rsv_ignored: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (wakeRequestClear == `WK_CLR_RSV_A || wakeRequestClear == `WK_CLR_RSV_B)
        |-> lnk.clearHit == '0)
        else $error("reserved clear code acted");
    // Level must belong to the granted source, judged where the pick was made
    chk_prio_grant: assert property (@(posedge sys_clk) disable iff (!rst_n)
        irqReq_nxt |=> (irqLevel_r == $past(intcPriorityLevel[irqSource_nxt])
        && irqLevel_r != `WK_PRIO_OFF))
        else $error("grant level mismatch");
    chk_grant_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !(|pend_r) |=> !irqReq_r)
        else $error("grant without pending source");
    // Sampled rst_n keeps the release edge out; flops still sit in reset there
    chk_high_follow: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (rst_n && intcSensitivitySel[RTC] == `WK_SENS_HIGH)
        |=> pend_r[RTC] == $past(intcIn[RTC]))
        else $error("high level pending wrong");
    chk_wake_flag: assert property (@(posedge sys_clk) disable iff (!rst_n)
        rst_n |=> wakeUp_r == $past(|lnk.condReq))
        else $error("wake flag does not follow detector");

    // Per-source controller checks; edge flags hold until their own clear
    genvar s;
    generate
        for (s = 0; s < NSRC; s++) begin : gChk
            chk_edge_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
                (rst_n && isEdgeSel(intcSensitivitySel[s]) && pend_r[s] && !intcHit[s])
                |=> pend_r[s])
                else $error("edge pending lost without clear");
            chk_edge_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
                (isEdgeSel(intcSensitivitySel[s]) && intcHit[s] && intcIn[s] == inPrev_r[s])
                |=> !pend_r[s])
                else $error("controller clear did not drop flag");
            chk_low_follow: assert property (@(posedge sys_clk) disable iff (!rst_n)
                (rst_n && intcSensitivitySel[s] == `WK_SENS_LOW) |=> pend_r[s] == !$past(intcIn[s]))
                else $error("low level pending wrong");
        end
    endgenerate

    // Coverage of the main scenarios
    cov_rtc_wake: cover property (@(posedge sys_clk) disable iff (!rst_n)
        lnk.condReq[RTC] ##1 wakeUp_r);
    cov_two_clear: cover property (@(posedge sys_clk) disable iff (!rst_n)
        wakeClearStrobe ##[1:4] intcClearStrobe);
    cov_grant: cover property (@(posedge sys_clk) disable iff (!rst_n)
        irqReq_r && irqLevel_r == 3'h5);
    cov_raw_edge: cover property (@(posedge sys_clk) disable iff (!rst_n)
        !routeWake[1] && pend_r[1] && intcSensitivitySel[1] == `WK_SENS_RISE);
    cov_rsv_code: cover property (@(posedge sys_clk) disable iff (!rst_n)
        wakeClearStrobe && wakeRequestClear == `WK_CLR_RSV_A);
endmodule // wakeup_interrupt_sensitivity

// [bench/irq_pin_model.sv]
// Behavioural model of the external interrupt pins and the RTC request line
`timescale 1ns/1ns
module irq_pin_model (
    // Clock
    input wire logic sys_clk,
    // Request lines toward the block
    output logic [4:0] extIrqPin,
    output logic rtcIrq
);
    // Lines idle low, so a falling edge needs a high phase first
    logic [5:0] lineLvl_r = 6'h00;

    // Five pins plus the RTC line
    assign extIrqPin = lineLvl_r[4:0];
    assign rtcIrq = lineLvl_r[5];

    // Changes land just after an edge, since the pins are synchronous
    task automatic drive(input logic [5:0] mask, input logic lvl);
        @(posedge sys_clk);
        lineLvl_r <= lvl ? (lineLvl_r | mask) : (lineLvl_r & ~mask);
    endtask
endmodule // irq_pin_model

// [bench/wakeup_interrupt_sensitivity_tb.sv]
// Self-checking testbench for the wake-up sensitivity block
`timescale 1ns/1ns
module wakeup_interrupt_sensitivity_tb;
    import wakeup_pkg::*;
    // Clock, reset and design ports
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [4:0] extIrqPin;
    logic rtcIrq;
    logic [5:0][1:0] wakeSensitivitySel = '0;
    logic [5:0] wakeEnable = '0;
    logic [4:0] wakeUse = '0;
    logic wakeClearStrobe = 1'b0;
    logic [2:0] wakeRequestClear = 3'h0;
    logic [5:0][1:0] intcSensitivitySel = '0;
    logic [5:0][2:0] intcPriorityLevel = '0;
    logic intcClearStrobe = 1'b0;
    logic [2:0] intcRequestClear = 3'h0;
    logic [5:0] intcPending;
    logic wakeUp;
    logic irqReq;
    logic [2:0] irqSource;
    logic [2:0] irqLevel;
    // Expected grants, bookkeeping and random state
    logic [5:0] expQ[$];
    logic [5:0] lastRes = 6'h00;
    logic [31:0] lfsr = 32'h3A849FC6;
    int n_mismatch = 0;
    int compares = 0;

    always #5 sys_clk = ~sys_clk;

    irq_pin_model src (.sys_clk(sys_clk), .extIrqPin(extIrqPin), .rtcIrq(rtcIrq));

    wakeup_interrupt_sensitivity #(.NUM_EXT(5)) dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .extIrqPin(extIrqPin), .rtcIrq(rtcIrq),
        .wakeSensitivitySel(wakeSensitivitySel), .wakeEnable(wakeEnable),
        .wakeUse(wakeUse), .wakeClearStrobe(wakeClearStrobe),
        .wakeRequestClear(wakeRequestClear), .intcSensitivitySel(intcSensitivitySel),
        .intcPriorityLevel(intcPriorityLevel), .intcClearStrobe(intcClearStrobe),
        .intcRequestClear(intcRequestClear), .intcPending(intcPending), .wakeUp(wakeUp),
        .irqReq(irqReq), .irqSource(irqSource), .irqLevel(irqLevel));

    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check(input logic [5:0] got, input logic [5:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic give_verdict();
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // One-cycle clear pulse on the wake side or the controller side
    task automatic strobe(input logic wk, input logic [2:0] code);
        @(posedge sys_clk);
        wakeClearStrobe <= wk;
        wakeRequestClear <= code;
        intcClearStrobe <= ~wk;
        intcRequestClear <= code;
        @(posedge sys_clk);
        wakeClearStrobe <= 1'b0;
        intcClearStrobe <= 1'b0;
    endtask

    // Bounded wait for every noted grant to be seen
    task automatic wait_q();
        int i;
        for (i = 0; i < 40 && expQ.size() != 0; i++) begin
            @(posedge sys_clk);
        end
        if (expQ.size() != 0) begin
            n_mismatch++;
            give_verdict();
        end
    endtask

    // Let the pipeline settle, then look at the request line
    task automatic settle(input logic exp);
        repeat (4) @(posedge sys_clk);
        #1;
        check({5'h00, irqReq}, {5'h00, exp});
    endtask

    // Each new grant takes the oldest note off the queue
    always @(posedge sys_clk) begin
        #1;
        if (irqReq === 1'b1 && {irqSource, irqLevel} !== lastRes) begin
            check({irqSource, irqLevel}, (expQ.size() != 0) ? expQ.pop_front() : 6'h00);
        end
        lastRes = (irqReq === 1'b1) ? {irqSource, irqLevel} : 6'h00;
    end

    initial begin
        int k;
        logic [2:0] pa;
        logic [2:0] pb;
        repeat (4) @(posedge sys_clk);
        #1;
        check({irqReq, wakeUp, 4'h0} | intcPending, 6'h00);
        @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        #1;
        // Default code 00 is low level and lines idle low, so all six pend
        check({irqReq, wakeUp, 4'h0}, 6'h00);
        check(intcPending, 6'h3F);
        // Pin 0 as falling-edge wake source, set up while disabled
        @(posedge sys_clk);
        wakeUse[0] <= 1'b1;
        wakeSensitivitySel[0] <= SENS_FALL;
        intcSensitivitySel[0] <= SENS_HIGH;
        strobe(1'b1, 3'h0);
        strobe(1'b0, 3'h0);
        @(posedge sys_clk);
        wakeEnable[0] <= 1'b1;
        intcPriorityLevel[0] <= 3'h5;
        src.drive(6'h01, 1'b1);
        settle(1'b0);
        expQ.push_back({3'h0, 3'h5});
        src.drive(6'h01, 1'b0);
        wait_q();
        settle(1'b1);
        check({5'h00, wakeUp}, 6'h01);
        strobe(1'b1, 3'h0);
        strobe(1'b0, 3'h0);
        settle(1'b0);
        check({5'h00, wakeUp}, 6'h00);
        // RTC wake; reserved clear codes must leave it pending
        @(posedge sys_clk);
        wakeSensitivitySel[5] <= SENS_FALL;
        intcSensitivitySel[5] <= SENS_HIGH;
        wakeEnable[5] <= 1'b1;
        strobe(1'b1, 3'h7);
        strobe(1'b0, 3'h5);
        // Priority only after the stale low-level flag has gone
        @(posedge sys_clk);
        intcPriorityLevel[5] <= 3'h7;
        src.drive(6'h20, 1'b1);
        expQ.push_back({3'h5, 3'h7});
        src.drive(6'h20, 1'b0);
        wait_q();
        for (k = 5; k < 7; k++) begin
            strobe(1'b1, k[2:0]);
        end
        strobe(1'b0, 3'h5);
        settle(1'b1);
        strobe(1'b1, 3'h7);
        strobe(1'b0, 3'h5);
        settle(1'b0);
        // Pin 1 left to the controller: detector low-level must not matter
        @(posedge sys_clk);
        wakeSensitivitySel[1] <= SENS_LOW;
        wakeEnable[1] <= 1'b1;
        intcSensitivitySel[1] <= SENS_RISE;
        // Drop the flag left from low-level sensing before giving a priority
        strobe(1'b0, 3'h1);
        @(posedge sys_clk);
        intcPriorityLevel[1] <= 3'h2;
        settle(1'b0);
        expQ.push_back({3'h1, 3'h2});
        src.drive(6'h02, 1'b1);
        wait_q();
        src.drive(6'h02, 1'b0);
        settle(1'b1);
        check({5'h00, intcPending[1]}, 6'h01);
        strobe(1'b0, 3'h1);
        settle(1'b0);
        // Random priorities on two level sources; a tie goes to the lower index
        @(posedge sys_clk);
        intcSensitivitySel[2] <= SENS_HIGH;
        intcSensitivitySel[3] <= SENS_HIGH;
        for (k = 0; k < 6; k++) begin
            lfsr = next_rand(lfsr);
            pa = (lfsr[2:0] == 3'h0) ? 3'h1 : lfsr[2:0];
            pb = (lfsr[5:3] == 3'h0) ? 3'h4 : lfsr[5:3];
            @(posedge sys_clk);
            intcPriorityLevel[2] <= pa;
            intcPriorityLevel[3] <= pb;
            expQ.push_back((pb > pa) ? {3'h3, pb} : {3'h2, pa});
            src.drive(6'h0C, 1'b1);
            wait_q();
            src.drive(6'h0C, 1'b0);
            settle(1'b0);
        end
        give_verdict();
    end
endmodule // wakeup_interrupt_sensitivity_tb
